/* File: asio_regs.vh */
// register map, field positions, reset values and timing for the address-shared io ports
`ifndef ASIO_REGS_VH
`define ASIO_REGS_VH
`define ASIO_OFS_PC_DIR 12'h000
`define ASIO_OFS_PC_ODR 12'h004
`define ASIO_OFS_PC_PIN 12'h008
`define ASIO_OFS_PC_PUC 12'h00C
`define ASIO_OFS_PB_DIR 12'h010
`define ASIO_OFS_PB_ODR 12'h014
`define ASIO_OFS_PB_PIN 12'h018
`define ASIO_OFS_PB_PUC 12'h01C
`define ASIO_OFS_PFC 12'h020
`define ASIO_OFS_CTRL 12'h024
`define ASIO_PFC_AE_LSB 0
`define ASIO_PFC_AE_MSB 3
`define ASIO_CTRL_MODE_LSB 0
`define ASIO_CTRL_MODE_MSB 2
`define ASIO_CTRL_STBY_BIT 3
`define ASIO_RST_BYTE 8'h00
`define ASIO_RST_AE 4'hF
`define ASIO_RST_MODE 3'h7
`define ASIO_SYNC_STAGES 2
`endif

/* File: asio_ports.v */
// address-shared port b (bits 2..0) and port c with apb register access
`timescale 1ns/1ps
`include "asio_regs.vh"
module asio_ports #(
	parameter PB_W = 3,
	parameter PC_W = 8
) (
	// clock, reset, enable
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	// external address bus source
	input wire [10:0] addr_bus,
	// port b pins 2..0
	input wire [PB_W-1:0] pb_in,
	output wire [PB_W-1:0] pb_out,
	output wire [PB_W-1:0] pb_oe,
	output wire [PB_W-1:0] pb_pullup,
	// port c pins 7..0
	input wire [PC_W-1:0] pc_in,
	output wire [PC_W-1:0] pc_out,
	output wire [PC_W-1:0] pc_oe,
	output wire [PC_W-1:0] pc_pullup
);
	reg [PC_W-1:0] pc_dir_q;
	reg [PC_W-1:0] pc_odr_q;
	reg [PC_W-1:0] pc_puc_q;
	reg [PB_W-1:0] pb_dir_q;
	reg [PB_W-1:0] pb_odr_q;
	reg [PB_W-1:0] pb_puc_q;
	reg [3:0] ae_q;
	reg [2:0] mode_q;
	reg stby_q;
	reg [PC_W-1:0] pc_s1_q;
	reg [PC_W-1:0] pc_s2_q;
	reg [PB_W-1:0] pb_s1_q;
	reg [PB_W-1:0] pb_s2_q;
	reg [31:0] rdata_d;
	wire wr_en;
	wire ext_mode;
	wire mode45;
	wire mode6;
	wire [PB_W-1:0] pb_addr_en;
	reg [PC_W-1:0] pc_addr_en;
	wire [PB_W-1:0] pb_gp_out;
	reg [PC_W-1:0] pc_gp_out;
	wire [PC_W-1:0] pc_rd;
	wire [PB_W-1:0] pb_rd;
	reg addr_hit;
	reg [1:0] mode_cls;
	reg [2:0] ae_dec;
	wire wr_pc_dir;
	wire wr_pc_odr;
	wire wr_pc_puc;
	wire wr_pb_dir;
	wire wr_pb_odr;
	wire wr_pb_puc;
	wire wr_pfc;
	wire wr_ctrl;
	wire [31:0] rd_pc_odr;
	wire [31:0] rd_pc_pin;
	wire [31:0] rd_pc_puc;
	wire [31:0] rd_pb_odr;
	wire [31:0] rd_pb_pin;
	wire [31:0] rd_pb_puc;
	wire [31:0] rd_pfc;
	wire [31:0] rd_ctrl;

	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite & clk_en;
	// mapped offsets; anything else answers with an error
	always @* begin
		addr_hit = 1'b0;
		case (paddr)
			`ASIO_OFS_PC_DIR: addr_hit = 1'b1;
			`ASIO_OFS_PC_ODR: addr_hit = 1'b1;
			`ASIO_OFS_PC_PIN: addr_hit = 1'b1;
			`ASIO_OFS_PC_PUC: addr_hit = 1'b1;
			`ASIO_OFS_PB_DIR: addr_hit = 1'b1;
			`ASIO_OFS_PB_ODR: addr_hit = 1'b1;
			`ASIO_OFS_PB_PIN: addr_hit = 1'b1;
			`ASIO_OFS_PB_PUC: addr_hit = 1'b1;
			`ASIO_OFS_PFC: addr_hit = 1'b1;
			`ASIO_OFS_CTRL: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_hit;

	// mode class; modes below 4 treated like mode 7 (single-chip)
	always @* begin
		mode_cls = 2'h0;
		case (mode_q)
			3'h4: mode_cls = 2'h1;
			3'h5: mode_cls = 2'h1;
			3'h6: mode_cls = 2'h2;
			3'h7: mode_cls = 2'h0;
			default: mode_cls = 2'h0;
		endcase
	end
	assign mode45 = (mode_cls == 2'h1);
	assign mode6 = (mode_cls == 2'h2);
	assign ext_mode = mode45 | mode6;

	// one strobe per register so each register lives in its own process
	assign wr_pc_dir = wr_en & (paddr == `ASIO_OFS_PC_DIR);
	assign wr_pc_odr = wr_en & (paddr == `ASIO_OFS_PC_ODR);
	assign wr_pc_puc = wr_en & (paddr == `ASIO_OFS_PC_PUC);
	assign wr_pb_dir = wr_en & (paddr == `ASIO_OFS_PB_DIR);
	assign wr_pb_odr = wr_en & (paddr == `ASIO_OFS_PB_ODR);
	assign wr_pb_puc = wr_en & (paddr == `ASIO_OFS_PB_PUC);
	assign wr_pfc = wr_en & (paddr == `ASIO_OFS_PFC);
	assign wr_ctrl = wr_en & (paddr == `ASIO_OFS_CTRL);

	// write-only: software must write whole bytes
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_dir_q <= {PC_W{1'b0}};
		end else if (wr_pc_dir) begin
			pc_dir_q <= pwdata[PC_W-1:0];
		end
	end

	// port c output data
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_odr_q <= {PC_W{1'b0}};
		end else if (wr_pc_odr) begin
			pc_odr_q <= pwdata[PC_W-1:0];
		end
	end

	// port c pull-up control
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_puc_q <= {PC_W{1'b0}};
		end else if (wr_pc_puc) begin
			pc_puc_q <= pwdata[PC_W-1:0];
		end
	end

	// port b direction, also write-only
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pb_dir_q <= {PB_W{1'b0}};
		end else if (wr_pb_dir) begin
			pb_dir_q <= pwdata[PB_W-1:0];
		end
	end

	// port b output data
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pb_odr_q <= {PB_W{1'b0}};
		end else if (wr_pb_odr) begin
			pb_odr_q <= pwdata[PB_W-1:0];
		end
	end

	// port b pull-up control
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pb_puc_q <= {PB_W{1'b0}};
		end else if (wr_pb_puc) begin
			pb_puc_q <= pwdata[PB_W-1:0];
		end
	end

	// address-enable field; reset value selects all upper lines for the bus in the expanded modes
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ae_q <= `ASIO_RST_AE;
		end else if (wr_pfc) begin
			ae_q <= pwdata[`ASIO_PFC_AE_MSB:`ASIO_PFC_AE_LSB];
		end
	end

	// operating mode and hardware standby
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= `ASIO_RST_MODE;
			stby_q <= 1'b0;
		end else if (wr_ctrl) begin
			mode_q <= pwdata[`ASIO_CTRL_MODE_MSB:`ASIO_CTRL_MODE_LSB];
			stby_q <= pwdata[`ASIO_CTRL_STBY_BIT];
		end
	end

	// port c synchroniser; first stage feeds only the second
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_s1_q <= {PC_W{1'b0}};
			pc_s2_q <= {PC_W{1'b0}};
		end else if (clk_en) begin
			pc_s1_q <= pc_in;
			pc_s2_q <= pc_s1_q;
		end
	end

	// port b synchroniser, same two-stage depth
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pb_s1_q <= {PB_W{1'b0}};
			pb_s2_q <= {PB_W{1'b0}};
		end else if (clk_en) begin
			pb_s1_q <= pb_in;
			pb_s2_q <= pb_s1_q;
		end
	end

	// field decode: which of a10..a8 go to the bus
	always @* begin
		ae_dec = 3'h0;
		case (ae_q)
			4'h0: ae_dec = 3'h0;
			4'h1: ae_dec = 3'h1;
			4'h2: ae_dec = 3'h3;
			4'h3: ae_dec = 3'h7;
			4'h4: ae_dec = 3'h7;
			4'h5: ae_dec = 3'h7;
			4'h6: ae_dec = 3'h7;
			4'h7: ae_dec = 3'h7;
			4'h8: ae_dec = 3'h7;
			4'h9: ae_dec = 3'h7;
			4'hA: ae_dec = 3'h7;
			4'hB: ae_dec = 3'h7;
			4'hC: ae_dec = 3'h7;
			4'hD: ae_dec = 3'h7;
			4'hE: ae_dec = 3'h7;
			4'hF: ae_dec = 3'h7;
			default: ae_dec = 3'h7;
		endcase
	end

	// port b address enables, only in the expanded modes
	assign pb_addr_en[2] = ext_mode & ae_dec[2];
	assign pb_addr_en[1] = ext_mode & ae_dec[1];
	assign pb_addr_en[0] = ext_mode & ae_dec[0];

	// port c address and general-output enables per mode class
	always @* begin
		pc_addr_en = {PC_W{1'b0}};
		pc_gp_out = {PC_W{1'b0}};
		case (mode_cls)
			2'h1: begin
				pc_addr_en = {PC_W{1'b1}};
			end
			2'h2: begin
				pc_addr_en = pc_dir_q;
			end
			2'h0: begin
				pc_gp_out = pc_dir_q;
			end
			default: begin
				pc_addr_en = {PC_W{1'b0}};
			end
		endcase
	end
	assign pb_gp_out = pb_dir_q & ~pb_addr_en;

	genvar i;
	generate
		// port c: address line, general output or input
		for (i = 0; i < PC_W; i = i + 1) begin : g_pc
			// address lines win over the data register
			assign pc_out[i] = pc_addr_en[i] ? addr_bus[i] : pc_odr_q[i];
			// standby floats every pin whatever the mode
			assign pc_oe[i] = stby_q ? 1'b0 : (pc_addr_en[i] | pc_gp_out[i]);
			// pull-up only on a true input, off in standby
			assign pc_pullup[i] = ~stby_q & ~pc_oe[i] & pc_puc_q[i] & ~pc_dir_q[i] & ~mode45;
			// outputs read the data register, inputs the synchronised pin
			assign pc_rd[i] = pc_dir_q[i] ? pc_odr_q[i] : pc_s2_q[i];
		end
		// port b: a10..a8, general output or input
		for (i = 0; i < PB_W; i = i + 1) begin : g_pb
			// upper address lines map onto bits 2..0
			assign pb_out[i] = pb_addr_en[i] ? addr_bus[8+i] : pb_odr_q[i];
			// standby floats every pin whatever the mode
			assign pb_oe[i] = stby_q ? 1'b0 : (pb_addr_en[i] | pb_gp_out[i]);
			// rstn low clears both control bits, so reset forces it off too
			assign pb_pullup[i] = ~stby_q & ~pb_addr_en[i] & ~pb_dir_q[i] & pb_puc_q[i];
			// same readback rule as port c
			assign pb_rd[i] = pb_dir_q[i] ? pb_odr_q[i] : pb_s2_q[i];
		end
	endgenerate

	// readable words, zero-extended to the bus width
	assign rd_pc_odr = {{(32-PC_W){1'b0}}, pc_odr_q};
	assign rd_pc_pin = {{(32-PC_W){1'b0}}, pc_rd};
	assign rd_pc_puc = {{(32-PC_W){1'b0}}, pc_puc_q};
	assign rd_pb_odr = {{(32-PB_W){1'b0}}, pb_odr_q};
	assign rd_pb_pin = {{(32-PB_W){1'b0}}, pb_rd};
	assign rd_pb_puc = {{(32-PB_W){1'b0}}, pb_puc_q};
	assign rd_pfc = {28'h0000000, ae_q};
	assign rd_ctrl = {28'h0000000, stby_q, mode_q};

	// read mux; direction registers read back as zero
	always @* begin
		rdata_d = 32'h00000000;
		case (paddr)
			`ASIO_OFS_PC_DIR: rdata_d = 32'h00000000;
			`ASIO_OFS_PC_ODR: rdata_d = rd_pc_odr;
			`ASIO_OFS_PC_PIN: rdata_d = rd_pc_pin;
			`ASIO_OFS_PC_PUC: rdata_d = rd_pc_puc;
			`ASIO_OFS_PB_DIR: rdata_d = 32'h00000000;
			`ASIO_OFS_PB_ODR: rdata_d = rd_pb_odr;
			`ASIO_OFS_PB_PIN: rdata_d = rd_pb_pin;
			`ASIO_OFS_PB_PUC: rdata_d = rd_pb_puc;
			`ASIO_OFS_PFC: rdata_d = rd_pfc;
			`ASIO_OFS_CTRL: rdata_d = rd_ctrl;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// read data registered in the setup cycle so it is valid in the access cycle;
	// loading early is what lets pready stay high with no wait state
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			prdata <= rdata_d;
		end
	end
endmodule

/* File: asio_pin_model.sv */
// far-side pin model for one port
`timescale 1ns/1ps
module asio_pin_model #(parameter W = 8) (
	// pins
	input wire [W-1:0] out,
	input wire [W-1:0] oe,
	input wire [W-1:0] pu,
	input wire [W-1:0] ext,
	output wire [W-1:0] pin
);
	// undriven pins take the board level unless pulled up
	assign pin = (oe & out) | (~oe & (pu | ext));
endmodule

/* File: asio_ports_checker.sv */
// assertions on the address-shared port pins
`timescale 1ns/1ps
module asio_ports_checker (
	input wire mclk, rstn, clk_en, psel, penable, pwrite, pready, pslverr,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [10:0] addr_bus,
	input wire [2:0] pb_in, pb_out, pb_oe, pb_pullup,
	input wire [7:0] pc_in, pc_out, pc_oe, pc_pullup
);
	reg [7:0] dir_q;
	reg [3:0] ae_q;
	reg [3:0] ctl_q;
	wire wr = psel & penable & pwrite & clk_en;
	wire m45 = ctl_q == 4'h4 || ctl_q == 4'h5;
	// mirror of the write-only port c direction, address-enable and mode registers
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dir_q <= 8'h00;
			ae_q <= 4'hF;
			ctl_q <= 4'h7;
		end else if (wr) begin
			if (paddr == 12'h000) dir_q <= pwdata[7:0];
			if (paddr == 12'h020) ae_q <= pwdata[3:0];
			if (paddr == 12'h024) ctl_q <= pwdata[3:0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_dir_rd;
		psel && !penable && !pwrite && paddr == 12'h000 && clk_en;
	endsequence
	a_pc_addr_all: assert property (m45 |-> pc_oe == 8'hFF && pc_out == addr_bus[7:0])
		else $error("port c not on address in mode 4/5");
	a_pc_addr_dir: assert property (ctl_q == 4'h6 |->
		pc_oe == dir_q && (pc_out & dir_q) == (addr_bus[7:0] & dir_q))
		else $error("port c mode 6 drive wrong");
	a_pc_gen_out: assert property (ctl_q == 4'h7 |-> pc_oe == dir_q)
		else $error("port c mode 7 enable wrong");
	a_pc_pull_in: assert property ((pc_pullup & pc_oe) == 8'h00)
		else $error("port c pull-up on driven pin");
	a_pb_pull_in: assert property ((pb_pullup & pb_oe) == 3'h0)
		else $error("port b pull-up on driven pin");
	a_stby_off: assert property (ctl_q[3] |-> pc_oe == 8'h00 && pb_pullup == 3'h0 && pc_pullup == 8'h00)
		else $error("standby left pins active");
	a_pb0_addr: assert property (ctl_q >= 4'h4 && ctl_q <= 4'h6 && ae_q != 4'h0 |-> pb_oe[0] && pb_out[0] == addr_bus[8])
		else $error("port b bit 0 not on address");
	a_dir_rd0: assert property (s_dir_rd ##1 (psel && penable) |-> prdata == 32'h0)
		else $error("direction register read back");
endmodule
bind asio_ports asio_ports_checker chk (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.addr_bus(addr_bus), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
	.pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pullup(pc_pullup));

/* File: testbench.sv */
// testbench for the address-shared io ports
`timescale 1ns/1ps
module testbench;
	reg mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, clk_en = 1;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg [10:0] addr_bus = 11'h5A3;
	reg rd_err;
	reg [3:0] ae;
	reg [2:0] am;
	wire pready, pslverr;
	wire [31:0] prdata;
	wire [2:0] pb_in, pb_out, pb_oe, pb_pullup;
	wire [7:0] pc_in, pc_out, pc_oe, pc_pullup;
	integer mismatches = 0, n_tests = 0, cyc = 0, i;
	asio_ports dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .addr_bus(addr_bus),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
		.pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pullup(pc_pullup));
	asio_pin_model #(.W(8)) pcm (.out(pc_out), .oe(pc_oe), .pu(pc_pullup), .ext(8'h05), .pin(pc_in));
	asio_pin_model #(.W(3)) pbm (.out(pb_out), .oe(pb_oe), .pu(pb_pullup), .ext(3'h2), .pin(pb_in));
	initial forever #2.5 mclk = ~mclk;
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", n_tests, mismatches);
			if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			mismatches = mismatches + 1;
			give_verdict;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	// one transfer; the trailing edge lets register updates land
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge mclk);
			penable <= 1;
			@(posedge mclk);
			while (pready !== 1'b1) @(posedge mclk);
			rd = prdata;
			rd_err = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge mclk);
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1;
		apb(0, 12'h004, 0); chk(rd, 0);
		apb(0, 12'h00C, 0); chk(rd, 0);
		apb(0, 12'h000, 0); chk(rd, 0);
		apb(0, 12'h040, 0); chk(rd_err, 1);
		// whole-byte direction writes, never read-modify-write
		apb(1, 12'h000, 8'hF0);
		apb(1, 12'h004, 8'hA5);
		apb(1, 12'h00C, 8'h3C);
		apb(0, 12'h004, 0); chk(rd, 8'hA5);
		// a frozen clock enable must swallow a write
		@(posedge mclk) clk_en <= 0;
		apb(1, 12'h004, 8'h11);
		@(posedge mclk) clk_en <= 1;
		apb(0, 12'h004, 0); chk(rd, 8'hA5);
		apb(0, 12'h008, 0); chk(rd, 8'hAD);
		chk({pc_oe, pc_out & pc_oe, pc_pullup}, 24'hF0A00C);
		apb(1, 12'h010, 3'h2);
		apb(1, 12'h01C, 3'h7);
		chk(pb_pullup, 3'h5);
		apb(1, 12'h024, 4'h6);
		chk({pc_oe, pc_out & 8'hF0}, 16'hF0A0);
		apb(1, 12'h000, 8'hFF); chk(pc_out, 8'hA3);
		apb(1, 12'h024, 4'h4);
		chk({pc_oe, pc_out, pc_pullup}, 24'hFFA300);
		for (i = 0; i < 6; i = i + 1) begin
			ae = (i == 5) ? 4'hF : i[3:0];
			apb(1, 12'h020, ae);
			am = {ae != 4'h2 && ae[3:1] != 3'h0, ae[3:1] != 3'h0, ae != 4'h0};
			chk(pb_oe, am | 3'h2);
			chk(pb_out & am, addr_bus[10:8] & am);
			chk(pb_pullup, ~am & 3'h5);
		end
		apb(1, 12'h024, 4'hF);
		chk({pc_oe, pc_pullup, pb_oe, pb_pullup}, 0);
		give_verdict;
	end
endmodule
